// *** tz_defines.svh ***
// register indices, byte addresses, field positions and reset values of the timer
`ifndef TZ_DEFINES_SVH
`define TZ_DEFINES_SVH
`define TZ_PADDR_W 12
`define TZ_IDX_COUNT_LOW 12'h318
`define TZ_IDX_HIGH 12'h319
`define TZ_IDX_CTL0 12'h31a
`define TZ_IDX_CTL1 12'h31b
`define TZ_IDX_IRQ 12'h31c
`define TZ_ADDR_COUNT_LOW 12'hc60
`define TZ_ADDR_HIGH 12'hc64
`define TZ_ADDR_CTL0 12'hc68
`define TZ_ADDR_CTL1 12'hc6c
`define TZ_ADDR_IRQ 12'hc70
`define TZ_CTL0_EN_BIT 7
`define TZ_CTL0_OUT_BIT 5
`define TZ_CTL0_WIDE_MODE_SELECT_BIT 4
`define TZ_IRQ_FLAG_BIT 0
`define TZ_IRQ_EN_BIT 1
`define TZ_RST_CTL0 8'h00
`define TZ_RST_CTL1 8'h00
`define TZ_RST_LOW 8'h00
`define TZ_RST_HIGH 8'hff
`define TZ_PRE_W 15
`endif

// *** tz_pkg.sv ***
// types shared by the timer: control layouts, source codes, source bundle
package tz_pkg;
   typedef enum logic [2:0] {
      TZ_SRC_PIN = 3'b000,
      TZ_SRC_PIN_INV = 3'b001,
      TZ_SRC_INSTR = 3'b010,
      TZ_SRC_HFINT = 3'b011,
      TZ_SRC_LFINT = 3'b100,
      TZ_SRC_MFINT = 3'b101,
      TZ_SRC_SOSC = 3'b110,
      TZ_SRC_LC1 = 3'b111
   } tz_src_e;

   typedef struct packed {
      logic en;
      logic rsv6;
      logic out;
      logic wide_mode_select;
      logic [3:0] postscale_select;
   } tz_ctl0_s;

   typedef struct packed {
      tz_src_e src;
      logic unsynced_input_select;
      logic [3:0] prescale_select;
   } tz_ctl1_s;

   // raw clock sources, all asynchronous to pclk
   typedef struct packed {
      logic lc1_out;
      logic sosc;
      logic mfint_500k;
      logic lfint;
      logic hfint;
      logic instr_clk;
      logic input_pin;
   } tz_src_s;
endpackage : tz_pkg

// *** tz_timer.sv ***
// timer with 8-bit period or 16-bit free-running count, prescaler, postscaler, apb slave
//
// Local design decision: register access over APB.
`include "tz_defines.svh"

// Functional notes
// (RL1) wide mode bit picks 16-bit counting, else 8-bit with period
// (RL2) counter advances on each prescaled rising edge of selected source
// (RL3) 8-bit: low byte vs buffered period; match clears and reloads buffer
// (RL4) 16-bit: reading low byte latches counter high byte into high register
// (RL5) 16-bit: writing low byte moves high register into counter high byte
// (RL6) 16-bit counter wraps from ffff to 0000 and runs on
// (RL7) enabled 16-bit counter is readable but ignores counter writes
// (RL8) synced input: counts only at instruction clock edges, never faster
// (RL9) unsynced input: counts at each prescaled edge, also during sleep
// (RL10) prescaler of sixteen ratios up to 1:32768, hidden from software
// (RL11) prescaler cleared by low byte write, control writes, reset
// (RL12) postscaler of sixteen ratios divides match or wrap events
// (RL13) postscaler hidden, cleared by low byte write, control writes, reset
// (RL14) output toggles on each postscaled match or wrap
// (RL15) output level readable at bit 5 of first control register
// (RL16) interrupt flag set whenever the output toggles
// (RL17) synced mode stops in sleep; unsynced keeps counting and wakes
// (RL18) enable bit 7 runs the module, resets to zero
// (RL19) postscale field gives ratio field plus one
// (RL20) source select field picks the input clock
// (RL21) source codes: 111 logic cell ... 000 plain input pin
// (RL22) prescale ratio is two to the power of the field
// (RL23) high register resets to 255, low byte to 0
// (RL24) control and counter writes reach count logic without partial updates
// (RL25) flag sticky until cleared; request is flag and enable
module tz_timer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`TZ_PADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire tz_pkg::tz_src_s sources,
   input wire logic sleep_mode,
   output logic timer_toggle_output,
   output logic timer_irq,
   output logic wake_request
);
   import tz_pkg::*;

   tz_ctl0_s ctl0, next_ctl0;
   tz_ctl1_s ctl1, next_ctl1;
   logic [7:0] count_low_byte, next_count_low_byte;
   logic [7:0] count_high, next_count_high;
   logic [7:0] period_or_count_high_byte, next_period_or_count_high_byte;
   logic [7:0] period_buf, next_period_buf;
   logic [`TZ_PRE_W-1:0] pre_cnt, next_pre_cnt;
   logic [3:0] post_cnt, next_post_cnt;
   logic pending, next_pending;
   logic toggle, next_toggle;
   logic timer_irq_flag, next_timer_irq_flag;
   logic timer_irq_enable, next_timer_irq_enable;
   logic [31:0] next_prdata;
   logic [7:0] src_raw, src_meta, src_sync;
   logic sel_prev, instr_prev;

   logic setup, access, wr, rd_setup, mapped;
   logic wr_low, wr_high, wr_ctl0, wr_ctl1, wr_irq, rd_low;
   logic sel_level, sel_rise, instr_rise, pre_tick, advance, event_hit, post_hit;
   logic [15:0] pre_shift;
   logic [`TZ_PRE_W-1:0] pre_lim;
   logic [15:0] wide_next;

   // apb decode; answer on the first access cycle
   assign setup = psel & ~penable;
   assign access = psel & penable;
   assign wr = access & pwrite;
   assign rd_setup = setup & ~pwrite;
   assign mapped = (paddr == `TZ_ADDR_COUNT_LOW) | (paddr == `TZ_ADDR_HIGH) |
                   (paddr == `TZ_ADDR_CTL0) | (paddr == `TZ_ADDR_CTL1) |
                   (paddr == `TZ_ADDR_IRQ);
   assign pready = access;
   assign pslverr = access & ~mapped;
   assign wr_low = wr & (paddr == `TZ_ADDR_COUNT_LOW);
   assign wr_high = wr & (paddr == `TZ_ADDR_HIGH);
   assign wr_ctl0 = wr & (paddr == `TZ_ADDR_CTL0);
   assign wr_ctl1 = wr & (paddr == `TZ_ADDR_CTL1);
   assign wr_irq = wr & (paddr == `TZ_ADDR_IRQ);
   assign rd_low = rd_setup & (paddr == `TZ_ADDR_COUNT_LOW);

   // raw sources in code order; inversion sits ahead of the synchroniser
   assign src_raw = {sources.lc1_out, sources.sosc, sources.mfint_500k, sources.lfint,
                     sources.hfint, sources.instr_clk, ~sources.input_pin,
                     sources.input_pin}; // RL21

   // two flops on every source, edges taken only from the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_meta <= 8'h00;
         src_sync <= 8'h00;
         sel_prev <= 1'b0;
         instr_prev <= 1'b0;
      end else begin
         src_meta <= src_raw;
         src_sync <= src_meta; // RL24
         sel_prev <= sel_level;
         instr_prev <= src_sync[TZ_SRC_INSTR];
      end
   end

   // source pick and prescaler terminal count
   assign sel_level = src_sync[ctl1.src]; // RL20
   assign sel_rise = sel_level & ~sel_prev & ctl0.en; // RL2 RL18
   assign instr_rise = src_sync[TZ_SRC_INSTR] & ~instr_prev;
   assign pre_shift = 16'h0001 << ctl1.prescale_select; // RL22
   assign pre_lim = pre_shift[`TZ_PRE_W-1:0] - 15'h0001;
   assign pre_tick = sel_rise & (pre_cnt == pre_lim); // RL10

   // synced mode waits for an instruction clock edge and halts in sleep
   always_comb begin
      next_pending = pending;
      advance = 1'b0;
      if (ctl1.unsynced_input_select) begin
         next_pending = 1'b0;
         advance = pre_tick; // RL9 RL17
      end else if (!sleep_mode) begin
         if (instr_rise) begin
            advance = pre_tick | pending; // RL8
            next_pending = 1'b0;
         end else if (pre_tick) begin
            next_pending = 1'b1;
         end
      end
      if (!ctl0.en || wr_low || wr_ctl0 || wr_ctl1) begin
         next_pending = 1'b0;
      end
   end

   assign wide_next = {count_high, count_low_byte} + 16'h0001; // RL6
   assign event_hit = advance & (ctl0.wide_mode_select ?
                      ({count_high, count_low_byte} == 16'hffff) :
                      (count_low_byte == period_buf)); // RL1
   assign post_hit = event_hit & (post_cnt == ctl0.postscale_select); // RL19

   // counter, period buffer, scalers, output and flag
   always_comb begin
      next_count_low_byte = count_low_byte;
      next_count_high = count_high;
      next_period_buf = period_buf;
      next_pre_cnt = pre_cnt;
      next_post_cnt = post_cnt;
      next_toggle = toggle;
      next_timer_irq_flag = timer_irq_flag;
      next_timer_irq_enable = timer_irq_enable;
      if (sel_rise) begin
         next_pre_cnt = pre_tick ? 15'h0000 : pre_cnt + 15'h0001; // RL10
      end
      if (advance) begin
         if (ctl0.wide_mode_select) begin
            next_count_low_byte = wide_next[7:0]; // RL6
            next_count_high = wide_next[15:8];
         end else if (event_hit) begin
            next_count_low_byte = 8'h00; // RL3
            next_period_buf = period_or_count_high_byte; // RL3
         end else begin
            next_count_low_byte = count_low_byte + 8'h01;
         end
      end
      if (event_hit) begin
         next_post_cnt = post_hit ? 4'h0 : post_cnt + 4'h1; // RL12
      end
      if (post_hit) begin
         next_toggle = ~toggle; // RL14
      end
      // software writes; a counter write is dropped while running wide
      if (wr_low && !(ctl0.en && ctl0.wide_mode_select)) begin // RL7
         next_count_low_byte = pwdata[7:0];
         if (ctl0.wide_mode_select) begin
            next_count_high = period_or_count_high_byte; // RL5
         end
      end
      if (wr_low || wr_ctl0 || wr_ctl1) begin
         next_pre_cnt = '0; // RL11
         next_post_cnt = 4'h0; // RL13
      end
      if (wr_irq) begin
         next_timer_irq_enable = pwdata[`TZ_IRQ_EN_BIT];
         if (pwdata[`TZ_IRQ_FLAG_BIT]) begin
            next_timer_irq_flag = 1'b0; // RL25
         end
      end
      if (post_hit) begin
         next_timer_irq_flag = 1'b1; // RL16
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_low_byte <= `TZ_RST_LOW; // RL23
         count_high <= 8'h00;
         period_buf <= `TZ_RST_HIGH;
         pre_cnt <= '0; // RL11
         post_cnt <= 4'h0; // RL13
         pending <= 1'b0;
         toggle <= 1'b0;
         timer_irq_flag <= 1'b0;
         timer_irq_enable <= 1'b0;
      end else begin
         count_low_byte <= next_count_low_byte;
         count_high <= next_count_high;
         period_buf <= next_period_buf;
         pre_cnt <= next_pre_cnt;
         post_cnt <= next_post_cnt;
         pending <= next_pending;
         toggle <= next_toggle;
         timer_irq_flag <= next_timer_irq_flag;
         timer_irq_enable <= next_timer_irq_enable;
      end
   end

   // control registers and the period or high byte register
   always_comb begin
      next_ctl0 = ctl0;
      next_ctl1 = ctl1;
      next_period_or_count_high_byte = period_or_count_high_byte;
      if (wr_ctl0) begin
         next_ctl0 = tz_ctl0_s'(pwdata[7:0]);
         next_ctl0.rsv6 = 1'b0;
         next_ctl0.out = 1'b0;
      end
      if (wr_ctl1) begin
         next_ctl1 = tz_ctl1_s'(pwdata[7:0]);
      end
      if (wr_high) begin
         next_period_or_count_high_byte = pwdata[7:0];
      end else if (rd_low && ctl0.wide_mode_select) begin
         next_period_or_count_high_byte = count_high; // RL4
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl0 <= tz_ctl0_s'(`TZ_RST_CTL0); // RL18
         ctl1 <= tz_ctl1_s'(`TZ_RST_CTL1);
         period_or_count_high_byte <= `TZ_RST_HIGH; // RL23
      end else begin
         ctl0 <= next_ctl0;
         ctl1 <= next_ctl1;
         period_or_count_high_byte <= next_period_or_count_high_byte;
      end
   end

   // read data captured in the setup cycle
   always_comb begin
      next_prdata = prdata;
      if (rd_setup) begin
         next_prdata = 32'h0000_0000;
         unique case (paddr)
            `TZ_ADDR_COUNT_LOW: next_prdata[7:0] = count_low_byte;
            `TZ_ADDR_HIGH: next_prdata[7:0] = period_or_count_high_byte;
            `TZ_ADDR_CTL0: next_prdata[7:0] = {ctl0.en, 1'b0, toggle, ctl0.wide_mode_select,
                                                ctl0.postscale_select}; // RL15
            `TZ_ADDR_CTL1: next_prdata[7:0] = ctl1;
            `TZ_ADDR_IRQ: next_prdata[1:0] = {timer_irq_enable, timer_irq_flag};
            default: next_prdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else begin
         prdata <= next_prdata;
      end
   end

   assign timer_toggle_output = toggle;
   assign timer_irq = timer_irq_flag & timer_irq_enable; // RL25
   assign wake_request = timer_irq & sleep_mode; // RL17
endmodule : tz_timer

// *** tz_timer_sva.sv ***
// assertion checker for the timer bus, interrupt and wake ports
`include "tz_defines.svh"
module tz_timer_sva (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`TZ_PADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire tz_pkg::tz_src_s sources,
   input wire logic sleep_mode,
   input wire logic timer_toggle_output,
   input wire logic timer_irq,
   input wire logic wake_request
);
   import tz_pkg::*;
   logic rd_set;
   logic acc;
   logic map;
   logic irq_wr;
   // decoded bus phases and address map
   assign rd_set = psel && !penable && !pwrite;
   assign acc = psel && penable;
   assign irq_wr = acc && pwrite && paddr == `TZ_ADDR_IRQ;
   assign map = paddr inside {`TZ_ADDR_COUNT_LOW, `TZ_ADDR_HIGH, `TZ_ADDR_CTL0,
      `TZ_ADDR_CTL1, `TZ_ADDR_IRQ};
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_READY: assert property (pready == acc)
      else $error("ready not tied to access phase");
   AST_ERR_MAP: assert property (acc |-> pslverr == !map)
      else $error("slave error does not match address map");
   AST_RD_UNMAP: assert property (rd_set && !map |=> prdata == 32'h0)
      else $error("unmapped read not zero");
   AST_OUT_BIT: assert property (
      rd_set && paddr == `TZ_ADDR_CTL0 |=> prdata[5] == $past(timer_toggle_output) && !prdata[6])
      else $error("control read does not show output level");
   AST_WAKE: assert property (wake_request == (timer_irq && sleep_mode))
      else $error("wake request wrong");
   AST_IRQ_FALL: assert property ($fell(timer_irq) |-> $past(irq_wr))
      else $error("interrupt dropped without software");
   AST_IRQ_RISE: assert property (
      $rose(timer_irq) |-> $changed(timer_toggle_output) || $past(irq_wr))
      else $error("interrupt rose without toggle");
   AST_IRQ_CLR: assert property (irq_wr && !pwdata[1] |=> !timer_irq)
      else $error("masked interrupt still requested");
   COV_TOG: cover property ($changed(timer_toggle_output));
   COV_WAKE: cover property ($rose(wake_request));
   COV_ERR: cover property (acc && pslverr);
endmodule : tz_timer_sva

// *** tz_timer_bench.sv ***
// self-checking bench for the timer
`include "tz_defines.svh"
module tz_timer_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import tz_pkg::*;
   localparam logic [11:0] a_lo = `TZ_ADDR_COUNT_LOW;
   localparam logic [11:0] a_hi = `TZ_ADDR_HIGH;
   localparam logic [11:0] a_c0 = `TZ_ADDR_CTL0;
   localparam logic [11:0] a_c1 = `TZ_ADDR_CTL1;
   localparam logic [11:0] a_iq = `TZ_ADDR_IRQ;
   logic pclk, presetn, psel, penable, pwrite, sleep_mode, pready, pslverr;
   logic tog, irq, wake, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [7:0] cnt;
   tz_src_s src;
   int err_total = 0;
   int n_checks = 0;
   int c;
   // pin and hfint at 8 pclk, instruction clock at 4 pclk, other sources held low
   assign src = {4'h0, cnt[2], cnt[1], cnt[2]};
   tz_timer dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .sources(src), .sleep_mode, .timer_toggle_output(tog),
      .timer_irq(irq), .wake_request(wake));
   // clock
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // source pattern counter
   always @(posedge pclk) begin
      cnt <= cnt + 8'h1;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // cycles until the output next changes, capped at lim
   task automatic wt(input int lim);
      logic o;
      o = tog;
      c = 0;
      while (tog === o && c < lim) begin
         @(posedge pclk);
         c++;
      end
   endtask : wt
   task automatic t_regs;
      apb(0, a_lo, 0); chk(q, 32'h0);
      apb(0, a_hi, 0); chk(q, 32'hff);
      apb(0, a_c1, 0); chk(q, 32'h0);
      apb(0, a_iq, 0); chk(q, 32'h0);
      apb(1, a_c0, 8'h7f);
      apb(0, a_c0, 0); chk(q, 32'h1f);
      apb(0, 12'h000, 0); chk({q[30:0], e}, 32'h1);
   endtask : t_regs
   // period 3, toggle spacing = edge period * prescale * 4 * (post + 1)
   task automatic t_rates;
      logic [7:0] cfg [4] = '{8'h10, 8'h30, 8'h72, 8'h40};
      logic [3:0] post [4] = '{4'h0, 4'h3, 4'h1, 4'h0};
      int exp [4] = '{32, 128, 256, 16};
      apb(1, a_hi, 8'h03);
      for (int i = 0; i < 4; i++) begin
         apb(1, a_c1, cfg[i]);
         apb(1, a_c0, {4'h8, post[i]});
         wt(6000);
         wt(6000);
         chk(c, exp[i]);
      end
      apb(0, a_iq, 0); chk(q, 32'h1);
      chk({31'h0, irq}, 32'h0);
   endtask : t_rates
   task automatic t_sleep;
      @(posedge pclk);
      sleep_mode <= 1'b1;
      wt(20);
      wt(300); chk(c, 300);
      apb(1, a_iq, 8'h03);
      apb(1, a_c1, 8'h10);
      wt(100); chk(c < 100, 1);
      chk({31'h0, wake}, 32'h1);
      sleep_mode <= 1'b0;
   endtask : t_sleep
   task automatic t_wide;
      apb(1, a_c0, 8'h10);
      apb(1, a_iq, 8'h01);
      // let the edge that takes the write settle before looking at the request
      @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      apb(1, a_hi, 8'hff);
      apb(1, a_lo, 8'hfe);
      apb(0, a_lo, 0); chk(q, 32'hfe);
      apb(0, a_hi, 0); chk(q, 32'hff);
      apb(1, a_c0, 8'h90);
      wt(200); chk(c < 200, 1);
      apb(0, a_lo, 0);
      apb(0, a_hi, 0); chk(q, 32'h0);
      apb(1, a_hi, 8'h77);
      apb(1, a_lo, 8'h55);
      apb(0, a_lo, 0);
      apb(0, a_hi, 0); chk(q, 32'h0);
   endtask : t_wide
   task automatic finish_test;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : finish_test
   // main sequence
   initial begin
      {psel, penable, pwrite, sleep_mode, presetn} = 5'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      cnt = 8'h0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_rates;
      t_sleep;
      t_wide;
      finish_test;
   end
   // watchdog
   initial begin
      #400us;
      err_total++;
      finish_test;
   end
endmodule : tz_timer_bench
bind tz_timer tz_timer_sva chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .sources, .sleep_mode, .timer_toggle_output,
   .timer_irq, .wake_request);
